/* File: core/apc_pkg.sv */
// Constants and helpers shared by the attribute palette controller files
package apc_pkg;
  // ==========================================================
  // Host I/O port addresses
  localparam logic [15:0] APC_PORT_ATTR = 16'h03C0; // Index/data port
  localparam logic [15:0] APC_PORT_ATTR_RD = 16'h03C1; // Data read port
  localparam logic [15:0] APC_PORT_SEQ_IDX = 16'h03C4; // Sequencer index
  localparam logic [15:0] APC_PORT_SEQ_DAT = 16'h03C5; // Sequencer data
  localparam logic [15:0] APC_PORT_STAT_MONO = 16'h03BA; // Status 1, mono
  localparam logic [15:0] APC_PORT_STAT_COLOR = 16'h03DA; // Status 1, color
  localparam logic [7:0] APC_EXT_ATTR_IDX = 8'h83; // Extension index

  // ==========================================================
  // Attribute data register indices
  localparam logic [4:0] APC_IDX_PAL_LAST = 5'h0F;
  localparam logic [4:0] APC_IDX_MODE = 5'h10;
  localparam logic [4:0] APC_IDX_OVERSCAN = 5'h11;
  localparam logic [4:0] APC_IDX_PLANE_EN = 5'h12;
  localparam logic [4:0] APC_IDX_PAN = 5'h13;
  localparam logic [4:0] APC_IDX_CSEL = 5'h14;

  // ==========================================================
  // Field positions
  localparam int APC_MODE_GFX = 0; // Graphics mode
  localparam int APC_MODE_MONO = 1; // Monochrome attributes
  localparam int APC_MODE_LINEGFX = 2; // Line graphics enable
  localparam int APC_MODE_BLINK = 3; // Blink enable
  localparam int APC_MODE_PANCOMP = 5; // Pixel pan compatibility
  localparam int APC_MODE_WIDE = 6; // 256-color pixel width
  localparam int APC_MODE_ALTSRC = 7; // Alternate video source
  localparam int APC_IDX_VEN_BIT = 5; // Video enable in index byte
  localparam int APC_EXT_TOG_BIT = 7; // Toggle in extension byte

  // ==========================================================
  // Misc values
  localparam logic [7:0] APC_LINEGFX_FIRST = 8'hC0; // Line graphics codes
  localparam logic [7:0] APC_LINEGFX_LAST = 8'hDF;
  localparam int APC_BLINK_FRAMES = 16; // Frames per blink state
  localparam int APC_BLINK_W = $clog2(APC_BLINK_FRAMES) + 1;
  localparam logic [7:0] APC_REG_RST = 8'h00; // Chosen reset value

  // Either status register 1 address
  function automatic logic apc_is_stat(input logic [15:0] a);
    return (a == APC_PORT_STAT_MONO) || (a == APC_PORT_STAT_COLOR);
  endfunction
endpackage

/* File: core/apc_stream_if.sv */
// Valid/ready stream carrier between the controller and its buffer
`timescale 1ns/1ps
interface apc_stream_if #(parameter int W = 8);
  logic valid; // Word offered
  logic ready; // Word taken when both high
  logic [W-1:0] data; // Word
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface // apc_stream_if

/* File: core/apc_skid.sv */
// Two-entry buffer on the video word path
`timescale 1ns/1ps
module apc_skid #(
  parameter int W = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  apc_stream_if.snk s_in,
  apc_stream_if.src s_out
);
  // ==========================================================
  // Storage: head entry always drives the output directly
  logic v0_q, v0_d, v1_q, v1_d; // Entry valid flags
  logic [W-1:0] d0_q, d0_d, d1_q, d1_d; // Entry words
  logic push, pop;
  logic rdy_q; // Room for a word, kept in its own flop

  // Ready only from a flop, so the source sees a clean stall
  assign s_in.ready = rdy_q;
  assign s_out.valid = v0_q;
  assign s_out.data = d0_q;
  assign push = s_in.valid && !v1_q;
  assign pop = v0_q && s_out.ready;

  // Next-state of the two entries
  always_comb begin
    v0_d = v0_q;
    v1_d = v1_q;
    d0_d = d0_q;
    d1_d = d1_q;
    if (pop && v1_q) begin
      // Tail moves to head, new word takes the tail
      d0_d = d1_q;
      v1_d = push;
      d1_d = push ? s_in.data : d1_q;
    end else if (pop) begin
      v0_d = push;
      d0_d = push ? s_in.data : d0_q;
    end else if (push && !v0_q) begin
      v0_d = 1'b1;
      d0_d = s_in.data;
    end else if (push) begin
      v1_d = 1'b1;
      d1_d = s_in.data;
    end
  end

  // Entry flops
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      v0_q <= 1'b0;
      v1_q <= 1'b0;
      rdy_q <= 1'b1;
      d0_q <= '0;
      d1_q <= '0;
    end else begin
      v0_q <= v0_d;
      v1_q <= v1_d;
      rdy_q <= !v1_d;
      d0_q <= d0_d;
      d1_q <= d1_d;
    end
  end

  // A stalled head word must not change under the receiver
  head_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    v0_q && !s_out.ready |=> v0_q && $stable(d0_q))
    else $error("buffer head changed while stalled");
endmodule // apc_skid

/* File: core/apc_top.sv */
// Attribute palette controller: host index/data ports, palette and video path
`timescale 1ns/1ps
module apc_top
  import apc_pkg::*;
(
  input wire logic i_ref_clk, // 40 MHz
  input wire logic i_rst_n, // Async, active low
  input wire logic [15:0] i_io_addr, // Host I/O address
  input wire logic i_io_rd, // Read strobe, one cycle
  input wire logic i_io_wr, // Write strobe, one cycle
  input wire logic [7:0] i_io_wdata, // Write data
  output logic [7:0] o_io_rdata, // Read data, held
  input wire logic i_px_valid, // Pixel offered
  output logic o_px_ready, // Pixel taken
  input wire logic [7:0] i_px_data, // Plane bits or 256-color byte
  input wire logic i_px_dot, // Text font dot
  input wire logic i_px_ninth, // Text pixel is ninth column
  input wire logic [7:0] i_px_attr, // Text attribute byte
  input wire logic [7:0] i_px_char, // Text character code
  input wire logic i_vretrace, // Vertical retrace level
  input wire logic i_line_cmp, // Line compare pulse
  input wire logic [1:0] i_byte_pan, // Preset row scan bits 6-5
  output logic [7:0] o_video, // Video word to external palette
  output logic o_video_valid, // Video word offered
  input wire logic i_video_ready, // Receiver takes word
  output logic [3:0] o_pan_count, // Pixel panning output
  output logic [1:0] o_byte_pan, // Byte panning output
  output logic o_half_rate // Shift register at half speed
);
  // ==========================================================
  // Register state
  logic [4:0] index_q; // Attribute index
  logic ven_q; // Video enable
  logic toggle_q; // 0 = index next, 1 = data next
  logic [7:0] seq_idx_q; // Sequencer index for extension port
  logic [7:0] pal_q [16]; // Palette entries
  logic [7:0] mode_q; // Mode control
  logic [7:0] ovs_q; // Overscan colour
  logic [7:0] plane_en_q; // Plane enable, stored only
  logic [7:0] pan_q; // Pixel pan shift
  logic [7:0] csel_q; // Colour select
  logic [7:0] rdata_q; // Held read data
  logic toggle_d;

  // ==========================================================
  // Host access decode
  logic wr_attr, rd_attr, rd_data, wr_seq_idx, ext_sel;
  logic wr_ext, rd_ext, rd_stat, idx_load, data_wr;
  logic [4:0] idx_new;
  logic ven_new;
  assign wr_attr = i_io_wr && (i_io_addr == APC_PORT_ATTR);
  assign rd_attr = i_io_rd && (i_io_addr == APC_PORT_ATTR);
  assign rd_data = i_io_rd && (i_io_addr == APC_PORT_ATTR_RD);
  assign wr_seq_idx = i_io_wr && (i_io_addr == APC_PORT_SEQ_IDX);
  assign ext_sel = (i_io_addr == APC_PORT_SEQ_DAT) && (seq_idx_q == APC_EXT_ATTR_IDX);
  assign wr_ext = i_io_wr && ext_sel;
  assign rd_ext = i_io_rd && ext_sel;
  assign rd_stat = i_io_rd && apc_is_stat(i_io_addr);
  // Index phase of the shared port, or the extension port
  assign idx_load = (wr_attr && !toggle_q) || wr_ext;
  assign data_wr = wr_attr && toggle_q;
  assign idx_new = i_io_wdata[4:0];
  assign ven_new = i_io_wdata[APC_IDX_VEN_BIT];

  // Toggle next value; reads of 3C0/3C1 fall to hold
  always_comb begin
    toggle_d = toggle_q;
    if (rd_stat) begin
      toggle_d = 1'b0;
    end else if (wr_ext) begin
      toggle_d = i_io_wdata[APC_EXT_TOG_BIT];
    end else if (wr_attr) begin
      toggle_d = !toggle_q;
    end
  end

  // ==========================================================
  // Palette address source
  logic [3:0] vid_addr; // Address from pixel stream
  logic [3:0] last_addr_q; // Last stream address taken
  logic [3:0] cpu_pal_addr;
  // With video on, the host hits whatever entry the stream points at
  assign cpu_pal_addr = ven_q ? last_addr_q : index_q[3:0];

  // Index, toggle and sequencer index
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      index_q <= '0;
      ven_q <= 1'b0;
      toggle_q <= 1'b0;
      seq_idx_q <= APC_REG_RST;
    end else begin
      toggle_q <= toggle_d;
      if (idx_load) begin
        index_q <= idx_new;
        ven_q <= ven_new;
      end
      if (wr_seq_idx) begin
        seq_idx_q <= i_io_wdata;
      end
    end
  end

  // Palette writes, one flop bank per entry
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_pal
      always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          pal_q[g] <= APC_REG_RST;
        end else if (data_wr && (index_q <= APC_IDX_PAL_LAST) && (cpu_pal_addr == 4'(g))) begin
          pal_q[g] <= i_io_wdata;
        end
      end
    end
  endgenerate

  // Control data registers above the palette
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_q <= APC_REG_RST;
      ovs_q <= APC_REG_RST;
      plane_en_q <= APC_REG_RST;
      pan_q <= APC_REG_RST;
      csel_q <= APC_REG_RST;
    end else if (data_wr) begin
      if (index_q == APC_IDX_MODE) mode_q <= i_io_wdata;
      if (index_q == APC_IDX_OVERSCAN) ovs_q <= i_io_wdata;
      if (index_q == APC_IDX_PLANE_EN) plane_en_q <= i_io_wdata;
      if (index_q == APC_IDX_PAN) pan_q <= i_io_wdata;
      if (index_q == APC_IDX_CSEL) csel_q <= i_io_wdata;
    end
  end

  // ==========================================================
  // Read data selection; unmapped indices read zero
  logic [7:0] data_sel, idx_byte, ext_byte;
  assign data_sel = (index_q <= APC_IDX_PAL_LAST) ? pal_q[cpu_pal_addr] :
                    (index_q == APC_IDX_MODE) ? mode_q :
                    (index_q == APC_IDX_OVERSCAN) ? ovs_q :
                    (index_q == APC_IDX_PLANE_EN) ? plane_en_q :
                    (index_q == APC_IDX_PAN) ? pan_q :
                    (index_q == APC_IDX_CSEL) ? csel_q : 8'h00;
  assign idx_byte = {2'b00, ven_q, index_q};
  assign ext_byte = {toggle_q, 1'b0, ven_q, index_q};

  // Read data flop holds until the next index, data or extension read; status reads leave it
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= APC_REG_RST;
    end else if (rd_attr) begin
      rdata_q <= idx_byte;
    end else if (rd_data) begin
      rdata_q <= data_sel;
    end else if (rd_ext) begin
      rdata_q <= ext_byte;
    end
  end
  assign o_io_rdata = rdata_q;

  // ==========================================================
  // Frame timing: blink counter and split-screen latch
  logic vr_q; // Retrace level last cycle
  logic vr_rise;
  logic [APC_BLINK_W-1:0] blink_cnt_q; // Frame counter
  logic phase; // Blink state
  logic split_q; // Below line compare
  logic pan_force;
  assign vr_rise = i_vretrace && !vr_q;
  // Top bit flips every 16 retraces: period of 32 frames
  assign phase = blink_cnt_q[APC_BLINK_W-1];
  assign pan_force = mode_q[APC_MODE_PANCOMP] && split_q;

  // Retrace edge, blink count and split latch
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vr_q <= 1'b0;
      blink_cnt_q <= '0;
      split_q <= 1'b0;
    end else begin
      vr_q <= i_vretrace;
      if (vr_rise) begin
        blink_cnt_q <= blink_cnt_q + 1'b1;
      end
      // A compare in the retrace cycle still counts
      if (i_line_cmp) begin
        split_q <= 1'b1;
      end else if (vr_rise) begin
        split_q <= 1'b0;
      end
    end
  end

  // Panning and rate outputs; a forced zero count in 9-dot mode
  // still moves the picture one pixel left in the shifter
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pan_count <= '0;
      o_byte_pan <= '0;
      o_half_rate <= 1'b0;
    end else begin
      o_pan_count <= pan_force ? 4'h0 : pan_q[3:0];
      o_byte_pan <= pan_force ? 2'h0 : i_byte_pan;
      o_half_rate <= mode_q[APC_MODE_WIDE];
    end
  end

  // ==========================================================
  // Pixel colour path
  logic gfx, blink_en, linegfx_code, ninth_dot, dot, txt_hide;
  logic last_dot_q; // Previous text dot (eighth column)
  logic a3;
  logic [3:0] txt_bg, txt_addr;
  logic [7:0] pal_v, mapped, color;
  logic px_take;
  assign gfx = mode_q[APC_MODE_GFX];
  assign blink_en = mode_q[APC_MODE_BLINK];
  assign linegfx_code = (i_px_char >= APC_LINEGFX_FIRST) && (i_px_char <= APC_LINEGFX_LAST);
  assign ninth_dot = mode_q[APC_MODE_LINEGFX] && linegfx_code && last_dot_q;
  assign dot = i_px_ninth ? ninth_dot : i_px_dot;
  // Blinking characters drop to background in one phase
  assign txt_hide = blink_en && i_px_attr[7] && phase;
  assign txt_bg = blink_en ? {1'b0, i_px_attr[6:4]} : i_px_attr[7:4];
  assign txt_addr = (dot && !txt_hide) ? i_px_attr[3:0] : txt_bg;
  // Palette input A3 in graphics modes
  assign a3 = !blink_en ? i_px_data[3] :
              mode_q[APC_MODE_MONO] ? phase :
              (i_px_data[3] ? phase : 1'b1);
  assign vid_addr = gfx ? {a3, i_px_data[2:0]} : txt_addr;
  assign pal_v = pal_q[vid_addr];
  assign mapped = {csel_q[3:2],
                   mode_q[APC_MODE_ALTSRC] ? csel_q[1:0] : pal_v[5:4],
                   pal_v[3:0]};
  // Video off wins; wide pixels skip the palette entirely
  assign color = !ven_q ? ovs_q :
                 mode_q[APC_MODE_WIDE] ? i_px_data : mapped;

  // ==========================================================
  // Buffer in the video path
  apc_stream_if #(.W(8)) pix_s ();
  apc_stream_if #(.W(8)) vid_s ();
  assign pix_s.valid = i_px_valid;
  assign pix_s.data = color;
  assign o_px_ready = pix_s.ready;
  assign px_take = i_px_valid && pix_s.ready;
  assign vid_s.ready = i_video_ready;
  assign o_video = vid_s.data;
  assign o_video_valid = vid_s.valid;

  apc_skid #(.W(8)) u_skid (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .s_in(pix_s),
    .s_out(vid_s)
  );

  // Stream history for line graphics and host palette addressing
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      last_dot_q <= 1'b0;
      last_addr_q <= '0;
    end else if (px_take) begin
      last_dot_q <= i_px_dot;
      last_addr_q <= vid_addr;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_port_write;
    wr_attr;
  endsequence
  sequence s_toggle_flipped;
    toggle_q != $past(toggle_q);
  endsequence

  toggle_flip_a: assert property (s_port_write |=> s_toggle_flipped)
    else $error("port write did not invert toggle");
  status_clear_a: assert property (rd_stat |=> !toggle_q)
    else $error("status read did not clear toggle");
  read_keep_a: assert property ((rd_attr || rd_data) |=> $stable(toggle_q) && $stable(index_q))
    else $error("port read disturbed toggle or index");
  index_load_a: assert property (wr_attr && !toggle_q |=> index_q == $past(i_io_wdata[4:0]) && toggle_q)
    else $error("index phase write not stored");
  ext_read_a: assert property (rd_ext |=> o_io_rdata[APC_EXT_TOG_BIT] == $past(toggle_q))
    else $error("extension read lost toggle state");
  blink_period_a: assert property ($changed(phase) |-> $past(blink_cnt_q[APC_BLINK_W-2:0]) == 4'hF)
    else $error("blink phase changed off the 16-frame boundary");
  split_zero_a: assert property (pan_force |=> o_pan_count == 4'h0 && o_byte_pan == 2'h0)
    else $error("panning not forced to zero below line compare");
  // Colour checks look at the buffer head, one edge after a take into an empty buffer
  overscan_a: assert property (px_take && !ven_q && !o_video_valid |=>
    o_video == $past(ovs_q))
    else $error("video off did not show overscan");
  bypass_a: assert property (px_take && ven_q && mode_q[APC_MODE_WIDE] && !o_video_valid |=>
    o_video == $past(i_px_data))
    else $error("wide pixel did not bypass palette");
  color_sel_a: assert property (px_take && ven_q && !mode_q[APC_MODE_WIDE] && !o_video_valid |=>
    o_video[7:6] == $past(csel_q[3:2]))
    else $error("video bits 6-7 not from colour select");

  // Host register paths, seen one edge after the access
  ext_write_a: assert property (wr_ext |=>
    toggle_q == $past(i_io_wdata[APC_EXT_TOG_BIT]) && index_q == $past(idx_new))
    else $error("extension write not loaded into toggle and index");
  pal_write_a: assert property (data_wr && (index_q <= APC_IDX_PAL_LAST) && !ven_q |=>
    pal_q[$past(index_q[3:0])] == $past(i_io_wdata))
    else $error("palette write missed the indexed entry");
  index_read_a: assert property (rd_attr |=> o_io_rdata == {2'h0, $past(ven_q), $past(index_q)})
    else $error("index read returned wrong byte");

  // Split latch: set by line compare, cleared by the next retrace rise
  split_set_a: assert property (i_line_cmp |=> split_q)
    else $error("line compare did not mark the lower screen");
  split_clear_a: assert property (vr_rise && !i_line_cmp |=> !split_q)
    else $error("retrace did not end the split region");
endmodule // apc_top

/* File: sim/apc_host_model.sv */
// Host CPU model issuing I/O port cycles to the attribute controller
`timescale 1ns/1ps
module apc_host_model
  import apc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic [7:0] i_io_rdata,
  output logic [15:0] o_io_addr,
  output logic o_io_rd,
  output logic o_io_wr,
  output logic [7:0] o_io_wdata
);
  // ==========================================================
  // Bus cycles
  initial begin
    o_io_addr = 16'h0000;
    o_io_rd = 1'b0;
    o_io_wr = 1'b0;
    o_io_wdata = 8'h00;
  end

  // One write strobe; released lines scrambled, never left at last value
  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    #1;
    o_io_addr = a;
    o_io_wdata = d;
    o_io_wr = 1'b1;
    @(posedge i_ref_clk);
    #1;
    o_io_wr = 1'b0;
    o_io_addr = ~a;
    o_io_wdata = ~d;
  endtask

  // Read strobe; data is held, so it is picked up a cycle later
  task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    #1;
    o_io_addr = a;
    o_io_rd = 1'b1;
    @(posedge i_ref_clk);
    #1;
    o_io_rd = 1'b0;
    o_io_addr = ~a;
    @(posedge i_ref_clk);
    #1;
    d = i_io_rdata;
  endtask

  // ==========================================================
  // Register access, always from a known toggle state
  task automatic reg_wr(input logic [4:0] idx, input logic [7:0] d);
    logic [7:0] s;
    io_rd(APC_PORT_STAT_COLOR, s);
    io_wr(APC_PORT_ATTR, {3'b000, idx});
    io_wr(APC_PORT_ATTR, d);
  endtask

  task automatic reg_rd(input logic [4:0] idx, output logic [7:0] d);
    logic [7:0] s;
    io_rd(APC_PORT_STAT_COLOR, s);
    io_wr(APC_PORT_ATTR, {3'b000, idx});
    io_rd(APC_PORT_ATTR_RD, d);
  endtask

  // Video on only after palette writes are done
  task automatic vid_on();
    logic [7:0] s;
    io_rd(APC_PORT_STAT_MONO, s);
    io_wr(APC_PORT_ATTR, 8'h20);
  endtask
endmodule // apc_host_model

/* File: sim/tb.sv */
// Self-checking testbench for the attribute palette controller
`timescale 1ns/1ps
module tb
  import apc_pkg::*;
;
  // ==========================================================
  // Signals
  logic i_ref_clk, i_rst_n, i_io_rd, i_io_wr;
  logic [15:0] i_io_addr;
  logic [7:0] i_io_wdata, o_io_rdata, i_px_data, i_px_attr, i_px_char, o_video;
  logic i_px_valid, o_px_ready, i_px_dot, i_px_ninth, i_vretrace, i_line_cmp;
  logic o_video_valid, i_video_ready, o_half_rate;
  logic [1:0] i_byte_pan, o_byte_pan;
  logic [3:0] o_pan_count;
  int n_errors = 0;
  int n_checks = 0;
  localparam logic [7:0] csel_val = 8'h06; // Distinct bits 1:0 and 3:2

  apc_top uut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_io_addr(i_io_addr), .i_io_rd(i_io_rd),
    .i_io_wr(i_io_wr), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata), .i_px_valid(i_px_valid),
    .o_px_ready(o_px_ready), .i_px_data(i_px_data), .i_px_dot(i_px_dot), .i_px_ninth(i_px_ninth),
    .i_px_attr(i_px_attr), .i_px_char(i_px_char), .i_vretrace(i_vretrace), .i_line_cmp(i_line_cmp),
    .i_byte_pan(i_byte_pan), .o_video(o_video), .o_video_valid(o_video_valid),
    .i_video_ready(i_video_ready), .o_pan_count(o_pan_count), .o_byte_pan(o_byte_pan),
    .o_half_rate(o_half_rate));
  apc_host_model host (.i_ref_clk(i_ref_clk), .i_io_rdata(o_io_rdata), .o_io_addr(i_io_addr),
    .o_io_rd(i_io_rd), .o_io_wr(i_io_wr), .o_io_wdata(i_io_wdata));

  // ==========================================================
  // Helpers
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Palette entry n holds {n,n}; top bits from colour select
  function automatic logic [7:0] ex(input logic [3:0] n, input logic alt);
    return {csel_val[3:2], alt ? csel_val[1:0] : n[1:0], n};
  endfunction

  // Offer one pixel, held until the ready seen before an edge
  task automatic px(input logic [7:0] d, input logic dot, input logic nin, input logic [7:0] at,
                    input logic [7:0] ch);
    logic ok;
    @(posedge i_ref_clk);
    #1;
    {i_px_data, i_px_dot, i_px_ninth, i_px_attr, i_px_char, i_px_valid} = {d, dot, nin, at, ch, 1'b1};
    ok = 1'b0;
    for (int k = 0; k < 20 && !ok; k++) begin
      ok = (o_px_ready === 1'b1);
      @(posedge i_ref_clk);
      #1;
    end
    {i_px_data, i_px_attr, i_px_char, i_px_valid} = {~d, ~at, ~ch, 1'b0};
    chk("px_taken", 8'h01, {7'h00, ok});
  endtask

  // Wait for the offered word, compare, let the taking edge pass
  task automatic rx(input string nm, input logic [7:0] e);
    logic got;
    got = 1'b0;
    for (int k = 0; k < 10 && !got; k++) begin
      if (o_video_valid === 1'b1) begin
        chk(nm, e, o_video);
        got = 1'b1;
      end else begin
        @(posedge i_ref_clk);
        #1;
      end
    end
    chk("video_valid", 8'h01, {7'h00, got});
    @(posedge i_ref_clk);
    #1;
  endtask

  task automatic vr();
    @(posedge i_ref_clk);
    #1;
    i_vretrace = 1'b1;
    @(posedge i_ref_clk);
    #1;
    i_vretrace = 1'b0;
  endtask

  task automatic settle();
    repeat (2) @(posedge i_ref_clk);
    #1;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_toggle();
    logic [7:0] r;
    host.io_rd(APC_PORT_STAT_COLOR, r);
    host.io_wr(APC_PORT_ATTR, 8'h10);
    host.io_rd(APC_PORT_ATTR, r);
    chk("index_rd", 8'h10, r);
    host.io_wr(APC_PORT_ATTR, 8'h08);
    host.io_rd(APC_PORT_ATTR_RD, r);
    chk("mode_rd", 8'h08, r);
    host.io_wr(APC_PORT_ATTR, 8'h10);
    host.io_rd(APC_PORT_ATTR_RD, r);
    host.io_wr(APC_PORT_ATTR, 8'h03);
    host.io_rd(APC_PORT_ATTR_RD, r);
    chk("data_after_rd", 8'h03, r);
    host.io_wr(APC_PORT_ATTR, 8'h10);
    host.io_rd(APC_PORT_STAT_MONO, r);
    host.io_wr(APC_PORT_ATTR, 8'h12);
    host.io_rd(APC_PORT_ATTR, r);
    chk("index_after_clr", 8'h12, r);
  endtask

  task automatic t_palette();
    logic [7:0] r;
    for (int i = 0; i < 16; i++) host.reg_wr(i[4:0], {i[3:0], i[3:0]});
    for (int i = 0; i < 16; i++) begin
      host.reg_rd(i[4:0], r);
      chk("palette", {i[3:0], i[3:0]}, r);
    end
    host.reg_wr(5'h15, 8'hFF);
    host.reg_rd(5'h15, r);
    chk("unmapped", 8'h00, r);
    host.reg_wr(APC_IDX_CSEL, csel_val);
  endtask

  task automatic t_ext();
    logic [7:0] r;
    host.io_wr(APC_PORT_SEQ_IDX, APC_EXT_ATTR_IDX);
    host.io_rd(APC_PORT_SEQ_DAT, r);
    chk("ext_rd", 8'h14, r);
    host.io_wr(APC_PORT_SEQ_DAT, 8'h91);
    host.io_rd(APC_PORT_SEQ_DAT, r);
    chk("ext_rd_tog", 8'h91, r);
    host.io_wr(APC_PORT_ATTR, 8'h5A);
    host.io_rd(APC_PORT_ATTR, r);
    chk("ext_index", 8'h11, r);
    host.reg_rd(APC_IDX_OVERSCAN, r);
    chk("overscan", 8'h5A, r);
    px(8'h07, 1'b0, 1'b0, 8'h00, 8'h00);
    rx("overscan_px", 8'h5A);
  endtask

  task automatic t_video();
    host.reg_wr(APC_IDX_MODE, 8'h01);
    host.vid_on();
    for (int i = 0; i < 16; i += 5) begin
      px(i[7:0], 1'b0, 1'b0, 8'h00, 8'h00);
      rx("gfx_px", ex(i[3:0], 1'b0));
    end
    host.reg_wr(APC_IDX_MODE, 8'h81);
    host.vid_on();
    px(8'h05, 1'b0, 1'b0, 8'h00, 8'h00);
    rx("alt_src", ex(4'h5, 1'b1));
    host.reg_wr(APC_IDX_MODE, 8'hC1);
    host.vid_on();
    px(8'hC3, 1'b0, 1'b0, 8'h00, 8'h00);
    rx("wide_px", 8'hC3);
    chk("half_rate", 8'h01, {7'h00, o_half_rate});
  endtask

  // Receiver stalls; two words held, source refused, order kept
  task automatic t_stall();
    i_video_ready = 1'b0;
    px(8'h01, 1'b0, 1'b0, 8'h00, 8'h00);
    px(8'h02, 1'b0, 1'b0, 8'h00, 8'h00);
    settle();
    chk("px_ready_full", 8'h00, {7'h00, o_px_ready});
    chk("held_word", 8'h01, o_video);
    i_video_ready = 1'b1;
    rx("drain_a", 8'h01);
    rx("drain_b", 8'h02);
  endtask

  task automatic t_blink();
    host.reg_wr(APC_IDX_MODE, 8'h09);
    host.vid_on();
    px(8'h02, 1'b0, 1'b0, 8'h00, 8'h00);
    rx("gfx_a3_set", ex(4'hA, 1'b0));
    px(8'h0A, 1'b0, 1'b0, 8'h00, 8'h00);
    rx("gfx_a3_blink", ex(4'h2, 1'b0));
    host.reg_wr(APC_IDX_MODE, 8'h0B);
    host.vid_on();
    repeat (15) vr();
    px(8'h02, 1'b0, 1'b0, 8'h00, 8'h00);
    rx("blink_15", ex(4'h2, 1'b0));
    vr();
    px(8'h02, 1'b0, 1'b0, 8'h00, 8'h00);
    rx("blink_16", ex(4'hA, 1'b0));
  endtask

  task automatic t_text();
    host.reg_wr(APC_IDX_MODE, 8'h04);
    host.vid_on();
    px(8'h00, 1'b1, 1'b0, 8'h1E, 8'hC4);
    rx("text_fg", ex(4'hE, 1'b0));
    px(8'h00, 1'b0, 1'b1, 8'h1E, 8'hC4);
    rx("ninth_copy", ex(4'hE, 1'b0));
    px(8'h00, 1'b1, 1'b1, 8'h1E, 8'h41);
    rx("ninth_bg", ex(4'h1, 1'b0));
    px(8'h00, 1'b0, 1'b0, 8'h9E, 8'h41);
    rx("bg_intense", ex(4'h9, 1'b0));
    host.reg_wr(APC_IDX_MODE, 8'h0C);
    host.vid_on();
    px(8'h00, 1'b1, 1'b0, 8'h9E, 8'h41);
    rx("text_blink", ex(4'h1, 1'b0));
  endtask

  task automatic t_pan();
    host.reg_wr(APC_IDX_PAN, 8'h07);
    host.reg_wr(APC_IDX_MODE, 8'h21);
    i_byte_pan = 2'b10;
    settle();
    chk("pan_on", 8'h07, {4'h0, o_pan_count});
    i_line_cmp = 1'b1;
    settle();
    i_line_cmp = 1'b0;
    settle();
    chk("pan_split", 8'h00, {4'h0, o_pan_count});
    chk("byte_split", 8'h00, {6'h00, o_byte_pan});
    vr();
    settle();
    chk("pan_frame", 8'h07, {4'h0, o_pan_count});
    chk("byte_frame", 8'h02, {6'h00, o_byte_pan});
    host.reg_wr(APC_IDX_MODE, 8'h01);
    i_line_cmp = 1'b1;
    settle();
    i_line_cmp = 1'b0;
    settle();
    chk("pan_both", 8'h07, {4'h0, o_pan_count});
  endtask

  // ==========================================================
  // Clock, sequence, watchdog
  task automatic summarize();
    if (n_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end

  initial begin
    {i_rst_n, i_px_valid, i_px_dot, i_px_ninth, i_vretrace, i_line_cmp} = 6'h00;
    {i_px_data, i_px_attr, i_px_char, i_byte_pan, i_video_ready} = {24'h000000, 2'b00, 1'b1};
    repeat (5) @(posedge i_ref_clk);
    #1;
    i_rst_n = 1'b1;
    t_toggle();
    t_palette();
    t_ext();
    t_video();
    t_stall();
    t_blink();
    t_text();
    t_pan();
    summarize();
  end

  // Run needs under a thousand cycles; 20000 is ample
  initial begin
    #500000;
    n_errors++;
    summarize();
  end
endmodule // tb
